// ===== rtl/drc_top.sv
// disk read command executor: task-file registers, native max and sector read
// Functional notes
// - opcode 27h reports native maximum block address
// - sector number gives bits 7:0 or 31:24
// - cylinder registers give 15:8/39:32 and 23:16/47:40
// - opcodes 20h/21h read sectors, retry bit ignored
// - sector data moves as 16-bit data words
// - sector count zero means 256 sectors
// - CHS start from sector, cylinder, head
// - LBA start built from four registers
// - uncorrectable error stops at failing sector
// - sector count returns sectors not transferred
// - CHS mode returns last transferred location, or the failing one after an error
// - LBA mode returns current block address
`timescale 1ns/100ps
`include "drc_defines.svh"
module drc_top (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  // ==========================================================
  // state
  drc_pkg::drc_state_t st_q;
  drc_pkg::drc_addr_t  addr_q;
  logic [7:0]  seccnt_q;
  logic [7:0]  devhead_q;
  logic [7:0]  status_q;
  logic [7:0]  error_q;
  logic        hob_q;
  logic        nmax_q;
  logic [8:0]  left_q;
  logic [27:0] blk_q;
  logic [8:0]  words_q;
  logic        first_q;
  logic        err_en_q;
  logic [27:0] err_blk_q;
  logic [47:0] nmax_v;

  // ==========================================================
  // bus decode
  logic        acc;
  logic        wr;
  logic        rd;
  logic        wr_cmd;
  logic        rd_data;
  logic        lba;
  logic [27:0] start_blk;

  assign acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr      = acc & wb_we_i & wb_sel_i[0];
  assign rd      = acc & ~wb_we_i;
  assign wr_cmd  = wr && (wb_adr_i == `DRC_OFF_STATUS) && (st_q == drc_pkg::DRC_IDLE);
  assign rd_data = rd && (wb_adr_i == `DRC_OFF_DATA);
  assign lba     = devhead_q[`DRC_DH_LBA];
  assign nmax_v  = `DRC_NATIVE_MAX;

  // LBA and CHS share the packing; CHS counts within the same fields
  assign start_blk = {devhead_q[3:0], addr_q.cyl_hi, addr_q.cyl_lo, addr_q.sec};

  // ==========================================================
  // data path
  logic [15:0] m_data;
  logic        m_valid;
  logic        m_ready;
  logic        m_bad;
  logic [15:0] f_data;
  logic        f_valid;
  logic        f_pop;
  logic        flush;
  logic        sec_start;

  assign flush     = (st_q != drc_pkg::DRC_XFER);
  assign f_pop     = rd_data && f_valid;
  assign sec_start = (st_q == drc_pkg::DRC_XFER) && first_q;

  drc_media u_media (
    .clk        (clk),
    .rst_b      (rst_b),
    .start      (sec_start),
    .blk        (blk_q),
    .err_blk_en (err_en_q),
    .err_blk    (err_blk_q),
    .out_ready  (m_ready),
    .out_data   (m_data),
    .out_valid  (m_valid),
    .bad        (m_bad)
  );

  drc_fifo #(
    .WIDTH (`DRC_WORD_W),
    .DEPTH (`DRC_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .flush     (flush),
    .in_data   (m_data),
    .in_valid  (m_valid && !first_q),
    .in_ready  (m_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // ==========================================================
  // command engine
  logic sec_done;
  assign sec_done = (st_q == drc_pkg::DRC_XFER) && !first_q && f_pop
                    && (words_q == `DRC_SEC_WORDS - 9'h001);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q    <= drc_pkg::DRC_IDLE;
      status_q <= 8'h50;
      error_q <= 8'h00;
      nmax_q  <= 1'b0;
      left_q  <= 9'h000;
      blk_q   <= 28'h0000000;
      words_q <= 9'h000;
      first_q <= 1'b0;
    end else begin
      unique case (st_q)
        drc_pkg::DRC_IDLE: begin
          if (wr_cmd) begin
            error_q <= 8'h00;
            if (wb_dat_i[7:0] == `DRC_OP_NATIVE_MAX) begin
              nmax_q   <= 1'b1;
              status_q <= 8'h50;
            end else if (wb_dat_i[7:1] == `DRC_OP_READ_SEC) begin
              nmax_q   <= 1'b0;
              left_q   <= (seccnt_q == 8'h00) ? 9'h100 : {1'b0, seccnt_q};
              blk_q    <= start_blk;
              words_q  <= 9'h000;
              first_q  <= 1'b1;
              status_q <= 8'hD0;
              st_q     <= drc_pkg::DRC_XFER;
            end else begin
              status_q <= 8'h51;
              error_q  <= 8'h04;
            end
          end
        end
        drc_pkg::DRC_XFER: begin
          status_q[`DRC_ST_BUSY] <= 1'b0;
          status_q[`DRC_ST_DREQ] <= 1'b1;
          if (first_q) begin
            first_q <= 1'b0;
          end else if (m_bad && !f_valid) begin
            status_q <= 8'h51;
            error_q  <= 8'h40;
            st_q     <= drc_pkg::DRC_DONE;
          end else if (f_pop) begin
            words_q <= sec_done ? 9'h000 : words_q + 9'h001;
            if (sec_done) begin
              left_q <= left_q - 9'h001;
              if (left_q == 9'h001) begin
                status_q <= 8'h50;
                st_q     <= drc_pkg::DRC_DONE;
              end else begin
                blk_q   <= blk_q + 28'h0000001;
                first_q <= 1'b1;
              end
            end
          end
        end
        drc_pkg::DRC_DONE: begin
          st_q <= drc_pkg::DRC_IDLE;
        end
        default: begin
          st_q <= drc_pkg::DRC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // task-file registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_q    <= '0;
      seccnt_q  <= 8'h00;
      devhead_q <= 8'hA0;
      hob_q     <= 1'b0;
      err_en_q  <= 1'b0;
      err_blk_q <= 28'h0000000;
    end else if (st_q == drc_pkg::DRC_DONE) begin
      seccnt_q <= left_q[7:0];
      // last transferred address or failing one
      addr_q.sec    <= blk_q[7:0];
      addr_q.cyl_lo <= blk_q[15:8];
      addr_q.cyl_hi <= blk_q[23:16];
      devhead_q     <= {devhead_q[7:4], blk_q[27:24]};
    end else if (wr && st_q == drc_pkg::DRC_IDLE) begin
      unique case (wb_adr_i)
        `DRC_OFF_SECCNT:  seccnt_q      <= wb_dat_i[7:0];
        `DRC_OFF_SECNUM:  addr_q.sec    <= wb_dat_i[7:0];
        `DRC_OFF_CYLLO:   addr_q.cyl_lo <= wb_dat_i[7:0];
        `DRC_OFF_CYLHI:   addr_q.cyl_hi <= wb_dat_i[7:0];
        `DRC_OFF_DEVHEAD: devhead_q     <= wb_dat_i[7:0];
        `DRC_OFF_CTRL:    hob_q         <= wb_dat_i[`DRC_CTRL_HOB];
        `DRC_OFF_MEDIA: begin
          err_en_q  <= wb_dat_i[28];
          err_blk_q <= wb_dat_i[27:0];
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // read mux and ack
  logic [7:0] sn_v;
  logic [7:0] cl_v;
  logic [7:0] ch_v;
  always_comb begin
    sn_v = addr_q.sec;
    cl_v = addr_q.cyl_lo;
    ch_v = addr_q.cyl_hi;
    if (nmax_q) begin
      sn_v = hob_q ? nmax_v[31:24] : nmax_v[7:0];
      cl_v = hob_q ? nmax_v[39:32] : nmax_v[15:8];
      ch_v = hob_q ? nmax_v[47:40] : nmax_v[23:16];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= acc;
      wb_dat_o <= 32'h00000000;
      if (rd) begin
        unique case (wb_adr_i)
          `DRC_OFF_DATA:    wb_dat_o <= {16'h0000, f_valid ? f_data : 16'h0000};
          `DRC_OFF_ERROR:   wb_dat_o <= {24'h000000, error_q};
          `DRC_OFF_SECCNT:  wb_dat_o <= {24'h000000, seccnt_q};
          `DRC_OFF_SECNUM:  wb_dat_o <= {24'h000000, sn_v};
          `DRC_OFF_CYLLO:   wb_dat_o <= {24'h000000, cl_v};
          `DRC_OFF_CYLHI:   wb_dat_o <= {24'h000000, ch_v};
          `DRC_OFF_DEVHEAD: wb_dat_o <= {24'h000000, devhead_q};
          `DRC_OFF_STATUS:  wb_dat_o <= {24'h000000, status_q};
          `DRC_OFF_CTRL:    wb_dat_o <= {24'h000000, hob_q, 7'h00};
          `DRC_OFF_MEDIA:   wb_dat_o <= {3'h0, err_en_q, err_blk_q};
          default:          wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  property p_ack_one;
    @(posedge clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack held two cycles");

  property p_nmax_lo;
    @(posedge clk) disable iff (!rst_b)
    (rd && wb_adr_i == `DRC_OFF_SECNUM && nmax_q && !hob_q) |=> wb_dat_o[7:0] == nmax_v[7:0];
  endproperty
  a_nmax_lo: assert property (p_nmax_lo) else $error("native max low byte wrong");

  property p_nmax_hi;
    @(posedge clk) disable iff (!rst_b)
    (rd && wb_adr_i == `DRC_OFF_CYLHI && nmax_q && hob_q) |=> wb_dat_o[7:0] == nmax_v[47:40];
  endproperty
  a_nmax_hi: assert property (p_nmax_hi) else $error("native max top byte wrong");

  property p_nmax_mid;
    @(posedge clk) disable iff (!rst_b)
    (rd && wb_adr_i == `DRC_OFF_CYLLO && nmax_q && !hob_q) |=> wb_dat_o[7:0] == nmax_v[15:8];
  endproperty
  a_nmax_mid: assert property (p_nmax_mid) else $error("native max byte one wrong");

  property p_nmax_ch_lo;
    @(posedge clk) disable iff (!rst_b)
    (rd && wb_adr_i == `DRC_OFF_CYLHI && nmax_q && !hob_q) |=> wb_dat_o[7:0] == nmax_v[23:16];
  endproperty
  a_nmax_ch_lo: assert property (p_nmax_ch_lo) else $error("native max byte two wrong");

  property p_nmax_sn_hi;
    @(posedge clk) disable iff (!rst_b)
    (rd && wb_adr_i == `DRC_OFF_SECNUM && nmax_q && hob_q) |=> wb_dat_o[7:0] == nmax_v[31:24];
  endproperty
  a_nmax_sn_hi: assert property (p_nmax_sn_hi) else $error("native max byte three wrong");

  property p_nmax_cl_hi;
    @(posedge clk) disable iff (!rst_b)
    (rd && wb_adr_i == `DRC_OFF_CYLLO && nmax_q && hob_q) |=> wb_dat_o[7:0] == nmax_v[39:32];
  endproperty
  a_nmax_cl_hi: assert property (p_nmax_cl_hi) else $error("native max byte four wrong");

  property p_ack_req;
    @(posedge clk) disable iff (!rst_b)
    acc |=> wb_ack_o;
  endproperty
  a_ack_req: assert property (p_ack_req) else $error("request not acknowledged");

  property p_read_go;
    @(posedge clk) disable iff (!rst_b)
    (wr_cmd && wb_dat_i[7:1] == `DRC_OP_READ_SEC)
      |=> st_q == drc_pkg::DRC_XFER && blk_q == $past(start_blk);
  endproperty
  a_read_go: assert property (p_read_go) else $error("read not started at address");

  property p_sec_next;
    @(posedge clk) disable iff (!rst_b)
    (sec_done && left_q != 9'h001) |=> first_q && blk_q == $past(blk_q) + 28'h0000001;
  endproperty
  a_sec_next: assert property (p_sec_next) else $error("next sector not consecutive");

  property p_zero_256;
    @(posedge clk) disable iff (!rst_b)
    (wr_cmd && wb_dat_i[7:1] == `DRC_OP_READ_SEC && seccnt_q == 8'h00) |=> left_q == 9'h100;
  endproperty
  a_zero_256: assert property (p_zero_256) else $error("count zero not 256");

  property p_bad_stop;
    @(posedge clk) disable iff (!rst_b)
    (st_q == drc_pkg::DRC_XFER && !first_q && m_bad && !f_valid)
      |=> st_q == drc_pkg::DRC_DONE && error_q[`DRC_ER_UNC];
  endproperty
  a_bad_stop: assert property (p_bad_stop) else $error("bad sector not stopping");

  property p_done_left;
    @(posedge clk) disable iff (!rst_b)
    (st_q == drc_pkg::DRC_DONE) |=> seccnt_q == $past(left_q[7:0]);
  endproperty
  a_done_left: assert property (p_done_left) else $error("remaining count wrong");

  property p_done_busy;
    @(posedge clk) disable iff (!rst_b)
    (st_q == drc_pkg::DRC_DONE) |-> !status_q[`DRC_ST_BUSY] && !status_q[`DRC_ST_FAULT];
  endproperty
  a_done_busy: assert property (p_done_busy) else $error("busy at completion");

  property p_abort;
    @(posedge clk) disable iff (!rst_b)
    (wr_cmd && wb_dat_i[7:0] != `DRC_OP_NATIVE_MAX && wb_dat_i[7:1] != `DRC_OP_READ_SEC)
      |=> error_q[`DRC_ER_ABT] && status_q[`DRC_ST_ERR];
  endproperty
  a_abort: assert property (p_abort) else $error("reject not aborted");

  property p_done_addr;
    @(posedge clk) disable iff (!rst_b)
    (st_q == drc_pkg::DRC_DONE) |=> addr_q.sec == $past(blk_q[7:0]);
  endproperty
  a_done_addr: assert property (p_done_addr) else $error("last address wrong");
endmodule

// ===== rtl/drc_defines.svh
// register map, field positions and constants for the disk read command executor
`ifndef DRC_DEFINES_SVH
`define DRC_DEFINES_SVH
`define DRC_OFF_DATA      8'h00
`define DRC_OFF_ERROR     8'h04
`define DRC_OFF_SECCNT    8'h08
`define DRC_OFF_SECNUM    8'h0C
`define DRC_OFF_CYLLO     8'h10
`define DRC_OFF_CYLHI     8'h14
`define DRC_OFF_DEVHEAD   8'h18
`define DRC_OFF_STATUS    8'h1C
`define DRC_OFF_CTRL      8'h20
`define DRC_OFF_MEDIA     8'h24
`define DRC_OP_NATIVE_MAX 8'h27
`define DRC_OP_READ_SEC   7'h10
`define DRC_SEC_WORDS     9'h100
`define DRC_ST_BUSY       7
`define DRC_ST_READY      6
`define DRC_ST_FAULT      5
`define DRC_ST_SEEK       4
`define DRC_ST_DREQ       3
`define DRC_ST_ERR        0
`define DRC_ER_UNC        6
`define DRC_ER_ABT        2
`define DRC_DH_LBA        6
`define DRC_CTRL_HOB      7
`define DRC_MEDIA_ERR     8
`define DRC_FIFO_DEPTH    8
`define DRC_WORD_W        16
// stand-in native max, every byte distinct
`define DRC_NATIVE_MAX    48'h6655_4433_2211
`endif

// ===== rtl/drc_pkg.sv
// types shared by the disk read command executor
package drc_pkg;
  typedef enum logic [1:0] {
    DRC_IDLE = 2'b00,
    DRC_XFER = 2'b01,
    DRC_DONE = 2'b10
  } drc_state_t;

  typedef struct packed {
    logic [7:0] sec;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [3:0] head;
  } drc_addr_t;
endpackage

// ===== rtl/drc_fifo.sv
// word fifo between media side and host data register
`timescale 1ns/100ps
module drc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             flush,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (flush) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule

// ===== rtl/drc_media.sv
// stand-in media source: yields sector words derived from block address
`timescale 1ns/100ps
`include "drc_defines.svh"
module drc_media (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        start,
  input  wire logic [27:0] blk,
  input  wire logic        err_blk_en,
  input  wire logic [27:0] err_blk,
  input  wire logic        out_ready,
  output logic [15:0]      out_data,
  output logic             out_valid,
  output logic             bad
);
  logic [8:0] idx_q;

  assign bad       = err_blk_en && (blk == err_blk);
  assign out_valid = (idx_q != `DRC_SEC_WORDS) && !bad;
  assign out_data  = blk[15:0] ^ {7'h00, idx_q};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      idx_q <= `DRC_SEC_WORDS;
    end else if (start) begin
      idx_q <= 9'h000;
    end else if (out_valid && out_ready) begin
      idx_q <= idx_q + 9'h001;
    end
  end
endmodule

// ===== tb/drc_host.sv
// bus master model of the host controller issuing task-file cycles
`timescale 1ns/100ps
module drc_host (
  input  wire logic        clk,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [7:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat_w,
  input  wire logic [31:0] dat_r,
  input  wire logic        ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    dat_w = 32'h0;
  end

  // one classic cycle; an edge always passes before the next request
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hF;
    dat_w <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    // released lines do not keep the old value
    adr <= ~a;
    dat_w <= ~d;
  endtask
endmodule

// ===== tb/drc_top_bench.sv
// self-checking bench for the disk read command executor
`timescale 1ns/100ps
`include "drc_defines.svh"
`define CHK(nm, e, s) begin tests_run++; if ((s) !== (e)) begin n_fail++; \
  $display("MISMATCH %s exp %h got %h", nm, e, s); end end
module drc_top_bench;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc, stb, we, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dw, dr;
  logic [63:0] e;
  logic [63:0] expq[$];
  int          n_fail = 0;
  int          tests_run = 0;

  always #2.5 clk = ~clk;

  drc_top DUT (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack));
  drc_host host (.clk(clk), .cyc(cyc), .stb(stb), .we(we), .adr(adr), .sel(sel),
    .dat_w(dw), .dat_r(dr), .ack(ack));

  // ==========
  // bus helpers
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    host.xfer(1'b1, a, d, x);
  endtask

  // note: mask zero marks an unchecked poll
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m,
                    output logic [31:0] v);
    expq.push_back({m, ex & m});
    host.xfer(1'b0, a, 32'h0, v);
  endtask

  task automatic wait_idle();
    logic [31:0] s;
    s = 32'hFF;
    for (int i = 0; i < 50 && s[`DRC_ST_BUSY] !== 1'b0; i++)
      rd(`DRC_OFF_STATUS, 32'h0, 32'h0, s);
  endtask

  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      e = expq.pop_front();
      if (e[63:32] != 32'h0)
        `CHK("rdata", e[31:0], dr & e[63:32])
    end
  end

  // ==========
  // commands
  task automatic native(input logic high_order_readback_select);
    logic [31:0] s;
    logic [47:0] m;
    m = `DRC_NATIVE_MAX;
    wr(`DRC_OFF_CTRL, {24'h0, high_order_readback_select, 7'h0});
    wr(`DRC_OFF_STATUS, 32'h27);
    wait_idle();
    rd(`DRC_OFF_SECNUM, {24'h0, high_order_readback_select ? m[31:24] : m[7:0]}, 32'hFF, s);
    rd(`DRC_OFF_CYLLO, {24'h0, high_order_readback_select ? m[39:32] : m[15:8]}, 32'hFF, s);
    rd(`DRC_OFF_CYLHI, {24'h0, high_order_readback_select ? m[47:40] : m[23:16]}, 32'hFF, s);
    rd(`DRC_OFF_STATUS, 32'h50, 32'hFF, s);
  endtask

  task automatic run_read(input logic [7:0] op, input logic lba, input logic [27:0] b,
                          input logic [7:0] cnt, input logic ee, input logic [27:0] eb);
    int          tot, good, w;
    logic [27:0] last;
    logic [31:0] s;
    tot = (cnt == 8'h00) ? 256 : int'(cnt);
    good = ee ? int'(eb - b) : tot;
    last = ee ? eb : b + 28'(tot - 1);
    w = 0;
    wr(`DRC_OFF_MEDIA, {3'h0, ee, eb});
    wr(`DRC_OFF_SECCNT, {24'h0, cnt});
    wr(`DRC_OFF_SECNUM, {24'h0, b[7:0]});
    wr(`DRC_OFF_CYLLO, {24'h0, b[15:8]});
    wr(`DRC_OFF_CYLHI, {24'h0, b[23:16]});
    wr(`DRC_OFF_DEVHEAD, {24'h0, 1'b1, lba, 1'b1, 1'b0, b[27:24]});
    wr(`DRC_OFF_STATUS, {24'h0, op});
    for (int i = 0; i < 20000; i++) begin
      rd(`DRC_OFF_STATUS, 32'h0, 32'h0, s);
      if (s[`DRC_ST_DREQ] === 1'b1) begin
        rd(`DRC_OFF_DATA, {16'h0, (b[15:0] + 16'(w / 256)) ^ 16'(w % 256)}, 32'hFFFF, s);
        w++;
        // busy device must drop task-file writes
        if (w == 100)
          wr(`DRC_OFF_SECNUM, 32'h5A);
        // long stalls let the word buffer fill up
        repeat ((w % 64 == 0) ? 20 : $urandom_range(2)) @(posedge clk);
      end else if (s[`DRC_ST_BUSY] === 1'b0) begin
        break;
      end
    end
    `CHK("words", good * 256, w)
    rd(`DRC_OFF_SECCNT, tot - good, 32'hFF, s);
    rd(`DRC_OFF_SECNUM, {24'h0, last[7:0]}, 32'hFF, s);
    rd(`DRC_OFF_CYLLO, {24'h0, last[15:8]}, 32'hFF, s);
    rd(`DRC_OFF_CYLHI, {24'h0, last[23:16]}, 32'hFF, s);
    rd(`DRC_OFF_DEVHEAD, {28'h0, last[27:24]}, 32'hF, s);
    rd(`DRC_OFF_ERROR, ee ? 32'h40 : 32'h0, 32'hFF, s);
    rd(`DRC_OFF_STATUS, ee ? 32'h51 : 32'h50, 32'hFF, s);
  endtask

  task tally_and_finish();
    if (n_fail == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ==========
  // main sequence
  initial begin
    logic [27:0] b;
    logic [31:0] s;
    void'($urandom(25435));
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    rd(`DRC_OFF_STATUS, 32'h50, 32'hFF, s);
    rd(`DRC_OFF_DEVHEAD, 32'hA0, 32'hFF, s);
    wr(8'h30, 32'h5A);
    rd(8'h30, 32'h0, 32'hFFFFFFFF, s);
    rd(`DRC_OFF_DATA, 32'h0, 32'hFFFFFFFF, s);
    wr(`DRC_OFF_STATUS, 32'hEE);
    wait_idle();
    rd(`DRC_OFF_ERROR, 32'h04, 32'hFF, s);
    rd(`DRC_OFF_STATUS, 32'h51, 32'hFF, s);
    b = {20'($urandom()), 8'hFF};
    run_read(8'h20, 1'b1, b, 8'h02, 1'b0, 28'h0);
    native(1'b1);
    native(1'b0);
    b = 28'($urandom());
    run_read(8'h21, 1'b0, b, 8'h01, 1'b0, 28'h0);
    b = 28'($urandom());
    run_read(8'h20, 1'b1, b, 8'h00, 1'b1, b + 28'h2);
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end
endmodule
